// ===== cfg_pkg.sv
// What this block does
// - Per-phase select: 1 auxiliary input, 0 temperature.
// - All four select bits reset to one.
// - Clock-disable bit 6 holds clock pin high.
// - Writing bit 7 starts remote converter reset.
// - Unlocked: three select-pin toggles switch to SPI.
// - SPI active: main config write locks SPI.
// - Lock and port survive software reset.
// - Hardware reset unlocks and selects two-wire port.
// - Reserved bits inert and reset to zero.
package cfg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] REMOTE_CFG_ADDR = 16'he708;
    localparam logic [15:0] LOCK_CFG_ADDR = 16'hea00;
    localparam logic [15:0] MAIN_CFG_ADDR = 16'he618;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SEL_A_BIT = 0;
    localparam int SEL_B_BIT = 1;
    localparam int SEL_C_BIT = 2;
    localparam int SEL_N_BIT = 3;
    localparam int CLK_DIS_BIT = 6;
    localparam int SOFT_RST_BIT = 7;
    localparam int LOCK_BIT = 0;

    // ------------------------------------------------------------------
    // Values after reset and counts
    // ------------------------------------------------------------------
    localparam logic [3:0] SEL_RESET = 4'hf;
    localparam logic CLK_DIS_RESET = 1'h0;
    localparam logic SOFT_RST_RESET = 1'h0;
    localparam logic LOCK_RESET = 1'h0;
    localparam logic [1:0] TOGGLES_TO_SPI = 2'h3;

    typedef enum logic {
        PORT_I2C = 1'b0,
        PORT_SPI = 1'b1
    } host_port_t;

endpackage

// ===== host_model.sv
`timescale 1ns/1ps
module host_model
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [15:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    output logic pin
);
    // ------------------------------------------------------------------
    // Host bus cycles
    // ------------------------------------------------------------------
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pin = 1'b1;
    end
    // Released data shows the inverse so a stale value cannot pass for a new one.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk);
        #1 reg_write = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_read = 1'b1;
        @(posedge clk);
        #1 reg_read = 1'b0;
        d = reg_rdata;
    endtask
    task automatic toggle3;
        repeat (3) begin
            repeat (6) @(posedge clk);
            #1 pin = ~pin;
        end
    endtask
endmodule

// ===== port_sel_if.sv
`timescale 1ns/1ps
interface port_sel_if;
    logic locked;
    logic spi_active;

    modport ctrl (
        output locked,
        input spi_active
    );

    modport sel (
        input locked,
        output spi_active
    );
endinterface

// ===== port_select.sv
`timescale 1ns/1ps
module port_select
    import cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic select_or_stream_ack_pin,
    port_sel_if.sel ps
);

    typedef struct packed {
        logic [2:0] sync;
        logic [1:0] fill;
        logic primed;
        logic stable;
        logic [1:0] toggles;
        host_port_t port;
    } sel_state_t;

    sel_state_t s_reg;
    sel_state_t s_next;
    logic toggle_seen;

    // ------------------------------------------------------------------
    // Pin filter and toggle counting
    // ------------------------------------------------------------------
    // The first agreed level only primes the filter, and only once all three
    // stages hold pin samples, so neither the cleared stages after reset nor
    // an unknown idle level of the pin is ever counted as a toggle.
    always_comb begin
        s_next = s_reg;
        toggle_seen = 1'b0;
        s_next.sync = {s_reg.sync[1:0], select_or_stream_ack_pin};
        if (!(&s_reg.fill)) begin
            s_next.fill = s_reg.fill + 2'h1;
        end
        if (s_reg.sync[1] == s_reg.sync[2]) begin
            if (!s_reg.primed && (&s_reg.fill)) begin
                s_next.primed = 1'b1;
                s_next.stable = s_reg.sync[2];
            end else if (s_reg.primed && s_reg.sync[2] != s_reg.stable) begin
                s_next.stable = s_reg.sync[2];
                toggle_seen = 1'b1;
            end
        end
        if (ps.locked) begin
            s_next.toggles = 2'h0;
        end else if (toggle_seen && s_reg.port == PORT_I2C) begin
            if (s_reg.toggles == TOGGLES_TO_SPI - 2'h1) begin
                s_next.port = PORT_SPI;
                s_next.toggles = 2'h0;
            end else begin
                s_next.toggles = s_reg.toggles + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '{sync: 3'h0, fill: 2'h0, primed: 1'b0, stable: 1'b0,
                       toggles: 2'h0, port: PORT_I2C};
        end else begin
            s_reg <= s_next;
        end
    end

    assign ps.spi_active = (s_reg.port == PORT_SPI);

endmodule

// ===== remote_cfg_lock.sv
`timescale 1ns/1ps
module remote_cfg_lock
    import cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chipset_soft_reset,
    input wire logic select_or_stream_ack_pin,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic phase_a_second_input_sel,
    output logic phase_b_second_input_sel,
    output logic phase_c_second_input_sel,
    output logic neutral_second_input_sel,
    output logic remote_clock_out_disable,
    output logic remote_clock_output_pin,
    output logic remote_converter_soft_reset,
    output logic host_port_is_spi,
    output logic port_locked
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] sel;
        logic clk_dis;
        logic soft_rst;
        logic lock;
        logic clk_pin;
        logic rst_pulse;
        logic [7:0] rdata;
    } cfg_state_t;

    cfg_state_t s_reg;
    cfg_state_t s_next;

    logic wr_remote;
    logic wr_lock;
    logic wr_main;
    logic [7:0] remote_view;
    logic [7:0] lock_view;

    port_sel_if ps ();

    port_select u_port_select (
        .clk(clk),
        .reset(reset),
        .select_or_stream_ack_pin(select_or_stream_ack_pin),
        .ps(ps.sel)
    );

    assign ps.locked = s_reg.lock;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign wr_remote = reg_write && (reg_addr == REMOTE_CFG_ADDR);
    assign wr_lock = reg_write && (reg_addr == LOCK_CFG_ADDR);
    assign wr_main = reg_write && (reg_addr == MAIN_CFG_ADDR);

    // ------------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------------
    // Reserved positions are wired to zero, so nothing written there can
    // ever reach the logic or read back.
    always_comb begin
        remote_view = 8'h00;
        remote_view[SEL_A_BIT] = s_reg.sel[0];
        remote_view[SEL_B_BIT] = s_reg.sel[1];
        remote_view[SEL_C_BIT] = s_reg.sel[2];
        remote_view[SEL_N_BIT] = s_reg.sel[3];
        remote_view[CLK_DIS_BIT] = s_reg.clk_dis;
        remote_view[SOFT_RST_BIT] = s_reg.soft_rst;
        lock_view = 8'h00;
        lock_view[LOCK_BIT] = s_reg.lock;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rst_pulse = 1'b0;

        // The remote reset bit reads one for a single cycle after it is
        // written, while the reset pulse goes out, and then clears.
        if (s_reg.soft_rst) begin
            s_next.soft_rst = 1'b0;
        end

        if (wr_remote) begin
            s_next.sel[0] = reg_wdata[SEL_A_BIT];
            s_next.sel[1] = reg_wdata[SEL_B_BIT];
            s_next.sel[2] = reg_wdata[SEL_C_BIT];
            s_next.sel[3] = reg_wdata[SEL_N_BIT];
            s_next.clk_dis = reg_wdata[CLK_DIS_BIT];
            if (reg_wdata[SOFT_RST_BIT]) begin
                s_next.soft_rst = 1'b1;
                s_next.rst_pulse = 1'b1;
            end
        end

        // Lock is sticky: only a hardware reset clears it, so a write of
        // zero after locking is ignored rather than reopening the port.
        if (wr_lock && reg_wdata[LOCK_BIT] && !ps.spi_active) begin
            s_next.lock = 1'b1;
        end
        if (wr_main && ps.spi_active) begin
            s_next.lock = 1'b1;
        end

        // A chipset software reset restores the converter settings but
        // leaves the port choice and its lock untouched.
        if (chipset_soft_reset) begin
            s_next.sel = SEL_RESET;
            s_next.clk_dis = CLK_DIS_RESET;
            s_next.soft_rst = SOFT_RST_RESET;
            s_next.rst_pulse = 1'b0;
            s_next.lock = s_reg.lock || s_next.lock;
        end

        // The clock pin runs at half the core clock and parks high while
        // disabled, so the converters see a static level, not a glitch.
        if (s_reg.clk_dis) begin
            s_next.clk_pin = 1'b1;
        end else begin
            s_next.clk_pin = ~s_reg.clk_pin;
        end

        if (reg_read) begin
            if (reg_addr == REMOTE_CFG_ADDR) begin
                s_next.rdata = remote_view;
            end else if (reg_addr == LOCK_CFG_ADDR) begin
                s_next.rdata = lock_view;
            end else begin
                s_next.rdata = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '{sel: SEL_RESET,
                       clk_dis: CLK_DIS_RESET,
                       soft_rst: SOFT_RST_RESET,
                       lock: LOCK_RESET,
                       clk_pin: 1'b1,
                       rst_pulse: 1'b0,
                       rdata: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = s_reg.rdata;
    assign phase_a_second_input_sel = s_reg.sel[0];
    assign phase_b_second_input_sel = s_reg.sel[1];
    assign phase_c_second_input_sel = s_reg.sel[2];
    assign neutral_second_input_sel = s_reg.sel[3];
    assign remote_clock_out_disable = s_reg.clk_dis;
    assign remote_clock_output_pin = s_reg.clk_pin;
    assign remote_converter_soft_reset = s_reg.rst_pulse;
    assign host_port_is_spi = ps.spi_active;
    assign port_locked = s_reg.lock;

endmodule

// ===== remote_cfg_lock_chk.sv
`timescale 1ns/1ps
module remote_cfg_lock_chk
    import cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chipset_soft_reset,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic phase_a_second_input_sel,
    input wire logic phase_b_second_input_sel,
    input wire logic phase_c_second_input_sel,
    input wire logic neutral_second_input_sel,
    input wire logic remote_clock_out_disable,
    input wire logic remote_clock_output_pin,
    input wire logic remote_converter_soft_reset,
    input wire logic host_port_is_spi,
    input wire logic port_locked
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic [3:0] sel = {neutral_second_input_sel, phase_c_second_input_sel,
        phase_b_second_input_sel, phase_a_second_input_sel};
    wire logic wr_cfg = reg_write && reg_addr == REMOTE_CFG_ADDR && !chipset_soft_reset;

    sel_follow_a: assert property (
        wr_cfg |=> sel == $past(reg_wdata[3:0])) else $error("select bits wrong");
    reset_value_a: assert property (
        $past(reset) |-> sel == SEL_RESET && !remote_clock_out_disable && !port_locked
        && !host_port_is_spi) else $error("reset values wrong");
    clk_high_a: assert property (
        remote_clock_out_disable && $past(remote_clock_out_disable)
        |-> remote_clock_output_pin) else $error("clock pin not high");
    clk_runs_a: assert property (
        !remote_clock_out_disable && !$past(remote_clock_out_disable)
        && !$past(remote_clock_out_disable, 2) && !$past(reset) && !$past(reset, 2)
        |-> remote_clock_output_pin != $past(remote_clock_output_pin))
        else $error("clock pin stuck");
    pulse_a: assert property (
        wr_cfg && reg_wdata[7] |=> remote_converter_soft_reset
        ##1 (!remote_converter_soft_reset || $past(wr_cfg && reg_wdata[7])))
        else $error("soft reset pulse wrong");
    spi_lock_a: assert property (
        reg_write && reg_addr == MAIN_CFG_ADDR && host_port_is_spi |=> port_locked)
        else $error("spi not locked");
    keep_lock_a: assert property (
        chipset_soft_reset && port_locked |=> port_locked
        && host_port_is_spi == $past(host_port_is_spi)) else $error("lock lost");
    locked_i2c_a: assert property (
        port_locked && !host_port_is_spi |=> !host_port_is_spi) else $error("port switched");
    cfg_rsvd_a: assert property (
        reg_read && reg_addr == REMOTE_CFG_ADDR |=> reg_rdata[5:4] == 2'h0)
        else $error("reserved bits set");
    lock_rsvd_a: assert property (
        reg_read && reg_addr == LOCK_CFG_ADDR |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved lock bits set");
endmodule

bind remote_cfg_lock remote_cfg_lock_chk i_remote_cfg_lock_chk (.*);

// ===== remote_cfg_lock_tb_top.sv
`timescale 1ns/1ps
module remote_cfg_lock_tb_top;
    import cfg_pkg::*;
    logic clk, reset, chipset_soft_reset, select_or_stream_ack_pin, reg_write, reg_read;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic phase_a_second_input_sel, phase_b_second_input_sel, phase_c_second_input_sel;
    logic neutral_second_input_sel, remote_clock_out_disable, remote_clock_output_pin;
    logic remote_converter_soft_reset, host_port_is_spi, port_locked, p;
    int num_errors = 0;
    int check_count = 0;
    wire logic [7:0] outs = {port_locked, host_port_is_spi, remote_converter_soft_reset,
        remote_clock_out_disable, neutral_second_input_sel, phase_c_second_input_sel,
        phase_b_second_input_sel, phase_a_second_input_sel};

    remote_cfg_lock i_remote_cfg_lock (.*);
    host_model i_host_model (.pin(select_or_stream_ack_pin), .*);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic hw_reset;
        reset = 1'b1;
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
    endtask
    task automatic soft_reset;
        @(posedge clk);
        #1 chipset_soft_reset = 1'b1;
        @(posedge clk);
        #1 chipset_soft_reset = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_select;
        for (int i = 0; i < 4; i++) begin
            i_host_model.wr(REMOTE_CFG_ADDR, 8'h3f ^ (8'h01 << i));
            i_host_model.rd(REMOTE_CFG_ADDR, d);
            chk(d, 8'h0f ^ (8'h01 << i));
            chk(outs, 8'h0f ^ (8'h01 << i));
        end
        $display("select done");
    endtask
    task automatic t_clock;
        i_host_model.wr(REMOTE_CFG_ADDR, 8'h4f);
        repeat (4) begin
            @(posedge clk);
            #1 chk(remote_clock_output_pin, 1'b1);
        end
        i_host_model.wr(REMOTE_CFG_ADDR, 8'h0f);
        repeat (2) @(posedge clk);
        #1 p = remote_clock_output_pin;
        @(posedge clk);
        #1 chk({7'h00, remote_clock_output_pin}, {7'h00, ~p});
        $display("clock done");
    endtask
    task automatic t_swrst;
        i_host_model.wr(REMOTE_CFG_ADDR, 8'h8f);
        chk(remote_converter_soft_reset, 1'b1);
        @(posedge clk);
        #1 chk(remote_converter_soft_reset, 1'b0);
        i_host_model.rd(REMOTE_CFG_ADDR, d);
        chk(d, 8'h0f);
        $display("soft reset done");
    endtask
    task automatic t_lock_i2c;
        i_host_model.wr(LOCK_CFG_ADDR, 8'hff);
        i_host_model.rd(LOCK_CFG_ADDR, d);
        chk(d, 8'h01);
        i_host_model.toggle3();
        repeat (8) @(posedge clk);
        i_host_model.wr(REMOTE_CFG_ADDR, 8'h40);
        soft_reset();
        chk(outs, 8'h8f);
        $display("i2c lock done");
    endtask
    task automatic t_spi;
        int n;
        hw_reset();
        chk(outs, 8'h0f);
        i_host_model.toggle3();
        for (n = 0; n < 20 && host_port_is_spi !== 1'b1; n++) @(posedge clk);
        #1 chk(host_port_is_spi, 1'b1);
        // A switch that never came is already counted; the caller ends the run.
        if (n == 20) return;
        i_host_model.wr(LOCK_CFG_ADDR, 8'h01);
        chk(port_locked, 1'b0);
        i_host_model.wr(MAIN_CFG_ADDR, 8'h00);
        chk(port_locked, 1'b1);
        soft_reset();
        chk(outs, 8'hcf);
        $display("spi lock done");
    endtask

    initial begin
        reset = 1'b1;
        chipset_soft_reset = 1'b0;
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        hw_reset();
        i_host_model.rd(REMOTE_CFG_ADDR, d);
        chk(d, 8'h0f);
        t_select();
        t_clock();
        t_swrst();
        t_lock_i2c();
        t_spi();
        end_of_test();
    end
endmodule
